// ==== design/ptmr_defines.vh ====
// ptmr_defines.vh: offsets, field positions, reset values and timing counts
// assumes: included by the periodic timer core, 32-bit axi4-lite word map
`ifndef PTMR_DEFINES_VH
`define PTMR_DEFINES_VH
// register byte addresses
`define PTMR_OFF_CTRL0     8'h00
`define PTMR_OFF_CTRL1     8'h04
`define PTMR_OFF_CNT_LO    8'h08
`define PTMR_OFF_CNT_HI    8'h0C
`define PTMR_OFF_CMPA_LO   8'h10
`define PTMR_OFF_CMPA_HI   8'h14
`define PTMR_OFF_CMPP_LO   8'h18
`define PTMR_OFF_CMPP_HI   8'h1C
`define PTMR_OFF_IRQ_STAT  8'h20
`define PTMR_OFF_IRQ_MASK  8'h24
// control 0 fields
`define PTMR_C0_PAUSE      7
`define PTMR_C0_CKSEL_HI   6
`define PTMR_C0_CKSEL_LO   4
`define PTMR_C0_ENABLE     3
// control 1 fields
`define PTMR_C1_MODE_HI    7
`define PTMR_C1_MODE_LO    6
`define PTMR_C1_OFUNC_HI   5
`define PTMR_C1_OFUNC_LO   4
`define PTMR_C1_OCTRL      3
`define PTMR_C1_POL        2
`define PTMR_C1_CLRSEL     0
// modes
`define PTMR_MODE_CMP      2'h0
`define PTMR_MODE_PWM      2'h2
`define PTMR_MODE_TMR      2'h3
// output functions
`define PTMR_OF_NONE       2'h0
`define PTMR_OF_LOW        2'h1
`define PTMR_OF_HIGH       2'h2
`define PTMR_OF_TOGGLE     2'h3
// clock selects
`define PTMR_CK_SYS4       3'h0
`define PTMR_CK_SYS        3'h1
`define PTMR_CK_H16        3'h2
`define PTMR_CK_H64        3'h3
`define PTMR_CK_EXT_RISE   3'h6
`define PTMR_CK_EXT_FALL   3'h7
// reset values and counter size
`define PTMR_RST_BYTE      8'h00
`define PTMR_CNT_MAX       10'h3FF
`define PTMR_DIV_W         6
// status bits: 0 compare a, 1 compare p, 2 overflow
`define PTMR_ST_W          3
`endif

// ==== design/ptmr_core.v ====
// ptmr_core.v: 10-bit periodic timer core with axi4-lite register slave
// assumes: one clock aclk, synchronous active-low reset, clock-enable style
// inputs high_clk_tick/sub_clk_tick from logic on the same clock
// Contract
// - four modes, one ext clock, two outputs
// - 10-bit up counter on selected clock
// - comparators A and P, 10 bits
// - no software write to the counter
// - auto clear on overflow or match, interrupts
// - count readable as low/high pair
// - compare values in read/write pairs
// - pause bit holds count, resumes later
// - bits 6..4 select count clock
// - enable bit runs or stops counter
// - enable rise clears count, fall holds
// - enable rise restores output initial level
// - control 0 bits 2..0 read zero
// - control 1 bits 7..6 select mode
// - compare mode: A match output action
// - output control sets initial/active level
// - clear source: P/overflow or A
//
// Decided for this implementation: the AXI4-Lite interface to the registers and the register offsets.
`include "ptmr_defines.vh"
module ptmr_core
(
  // clock and reset
  input  wire        aclk,
  input  wire        aresetn,
  // axi4-lite write address
  input  wire [7:0]  s_axi_awaddr,
  input  wire        s_axi_awvalid,
  output wire        s_axi_awready,
  // axi4-lite write data
  input  wire [31:0] s_axi_wdata,
  input  wire [3:0]  s_axi_wstrb,
  input  wire        s_axi_wvalid,
  output wire        s_axi_wready,
  // axi4-lite write response
  output reg  [1:0]  s_axi_bresp,
  output reg         s_axi_bvalid,
  input  wire        s_axi_bready,
  // axi4-lite read address
  input  wire [7:0]  s_axi_araddr,
  input  wire        s_axi_arvalid,
  output wire        s_axi_arready,
  // axi4-lite read data
  output reg  [31:0] s_axi_rdata,
  output reg  [1:0]  s_axi_rresp,
  output reg         s_axi_rvalid,
  input  wire        s_axi_rready,
  // internal clock ticks (one-cycle enables, same clock)
  input  wire        high_clk_tick,
  input  wire        sub_clk_tick,
  // pins
  input  wire        ext_count_clock_pin,
  output reg         timer_out,
  output reg         timer_out_n,
  // interrupt
  output reg         irq
);

////////////////////////////////////////////////////////////////////////////////
// registers
reg [7:0]  ctrl0;
reg [7:0]  ctrl1;
reg [9:0]  compare_a_value;
reg [9:0]  compare_p_value;
reg [9:0]  count;
reg [`PTMR_ST_W-1:0] irq_stat;
reg [`PTMR_ST_W-1:0] irq_mask;
reg        out_level;
reg        enable_d;

wire       count_pause          = ctrl0[`PTMR_C0_PAUSE];
wire [2:0] count_clock_select   = ctrl0[`PTMR_C0_CKSEL_HI:`PTMR_C0_CKSEL_LO];
wire       counter_enable       = ctrl0[`PTMR_C0_ENABLE];
wire [1:0] operating_mode_select  = ctrl1[`PTMR_C1_MODE_HI:`PTMR_C1_MODE_LO];
wire [1:0] output_function_select = ctrl1[`PTMR_C1_OFUNC_HI:`PTMR_C1_OFUNC_LO];
wire       output_control       = ctrl1[`PTMR_C1_OCTRL];
wire       output_polarity      = ctrl1[`PTMR_C1_POL];
wire       counter_clear_select = ctrl1[`PTMR_C1_CLRSEL];

////////////////////////////////////////////////////////////////////////////////
// axi4-lite slave: address and data taken in either order, one write at a time
reg        aw_held;
reg        w_held;
reg [7:0]  aw_addr;
reg [31:0] w_data;
reg [3:0]  w_strb;
assign s_axi_awready = ~aw_held & ~s_axi_bvalid;
assign s_axi_wready  = ~w_held & ~s_axi_bvalid;
assign s_axi_arready = ~s_axi_rvalid;

wire       aw_take  = s_axi_awvalid & s_axi_awready;
wire       w_take   = s_axi_wvalid & s_axi_wready;
wire       wr_go    = (aw_held | aw_take) & (w_held | w_take);
wire [7:0] wr_addr  = aw_held ? aw_addr : s_axi_awaddr;
wire [31:0] wr_data = w_held ? w_data : s_axi_wdata;
wire [3:0] wr_strb  = w_held ? w_strb : s_axi_wstrb;
// only byte lane 0 carries register data
wire       wr_lane0 = wr_go & wr_strb[0];
wire [7:0] wb       = wr_data[7:0];
function addr_known;
  input [7:0] a;
  begin
    addr_known = (a[1:0] == 2'h0) && (a <= `PTMR_OFF_IRQ_MASK);
  end
endfunction
function wr_hit;
  input [7:0] a;
  input [7:0] off;
  begin
    wr_hit = (a == off);
  end
endfunction

always @(posedge aclk)
begin
  if (!aresetn)
  begin
    aw_held      <= 1'b0;
    w_held       <= 1'b0;
    aw_addr      <= 8'h00;
    w_data       <= 32'h00000000;
    w_strb       <= 4'h0;
    s_axi_bvalid <= 1'b0;
    s_axi_bresp  <= 2'h0;
  end
  else
  begin
    if (wr_go)
    begin
      aw_held      <= 1'b0;
      w_held       <= 1'b0;
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= addr_known(wr_addr) ? 2'h0 : 2'h2;
    end
    else
    begin
      if (aw_take)
      begin
        aw_held <= 1'b1;
        aw_addr <= s_axi_awaddr;
      end
      if (w_take)
      begin
        w_held <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end
      if (s_axi_bvalid && s_axi_bready)
        s_axi_bvalid <= 1'b0;
    end
  end
end

// read data is captured at the address handshake, so it reflects that cycle
always @(posedge aclk)
begin
  if (!aresetn)
  begin
    s_axi_rvalid <= 1'b0;
    s_axi_rdata  <= 32'h00000000;
    s_axi_rresp  <= 2'h0;
  end
  else if (s_axi_arvalid && s_axi_arready)
  begin
    s_axi_rvalid <= 1'b1;
    s_axi_rresp  <= addr_known(s_axi_araddr) ? 2'h0 : 2'h2;
    s_axi_rdata  <= 32'h00000000;
    if (s_axi_araddr == `PTMR_OFF_CTRL0)
      s_axi_rdata[7:0] <= {ctrl0[7:3], 3'h0};
    else if (s_axi_araddr == `PTMR_OFF_CTRL1)
      s_axi_rdata[7:0] <= ctrl1;
    else if (s_axi_araddr == `PTMR_OFF_CNT_LO)
      s_axi_rdata[7:0] <= count[7:0];
    else if (s_axi_araddr == `PTMR_OFF_CNT_HI)
      s_axi_rdata[1:0] <= count[9:8];
    else if (s_axi_araddr == `PTMR_OFF_CMPA_LO)
      s_axi_rdata[7:0] <= compare_a_value[7:0];
    else if (s_axi_araddr == `PTMR_OFF_CMPA_HI)
      s_axi_rdata[1:0] <= compare_a_value[9:8];
    else if (s_axi_araddr == `PTMR_OFF_CMPP_LO)
      s_axi_rdata[7:0] <= compare_p_value[7:0];
    else if (s_axi_araddr == `PTMR_OFF_CMPP_HI)
      s_axi_rdata[1:0] <= compare_p_value[9:8];
    else if (s_axi_araddr == `PTMR_OFF_IRQ_STAT)
      s_axi_rdata[`PTMR_ST_W-1:0] <= irq_stat;
    else if (s_axi_araddr == `PTMR_OFF_IRQ_MASK)
      s_axi_rdata[`PTMR_ST_W-1:0] <= irq_mask;
  end
  else if (s_axi_rvalid && s_axi_rready)
    s_axi_rvalid <= 1'b0;
end

////////////////////////////////////////////////////////////////////////////////
// count clock selection
reg        ext_s1;
reg        ext_s2;
reg        ext_s3;
reg [`PTMR_DIV_W-1:0] sys_div;
reg [`PTMR_DIV_W-1:0] high_div;

always @(posedge aclk)
begin
  if (!aresetn)
  begin
    ext_s1   <= 1'b0;
    ext_s2   <= 1'b0;
    ext_s3   <= 1'b0;
    sys_div  <= 6'h00;
    high_div <= 6'h00;
  end
  else
  begin
    ext_s1   <= ext_count_clock_pin;
    ext_s2   <= ext_s1;
    ext_s3   <= ext_s2;
    sys_div  <= sys_div + 6'h01;
    if (high_clk_tick)
      high_div <= high_div + 6'h01;
  end
end
reg count_tick;
always @*
begin
  case (count_clock_select)
    `PTMR_CK_SYS4:     count_tick = (sys_div[1:0] == 2'h3);
    `PTMR_CK_SYS:      count_tick = 1'b1;
    `PTMR_CK_H16:      count_tick = high_clk_tick & (high_div[3:0] == 4'hF);
    `PTMR_CK_H64:      count_tick = high_clk_tick & (high_div == 6'h3F);
    `PTMR_CK_EXT_RISE: count_tick = ext_s2 & ~ext_s3;
    `PTMR_CK_EXT_FALL: count_tick = ~ext_s2 & ext_s3;
    default:           count_tick = sub_clk_tick;
  endcase
end

////////////////////////////////////////////////////////////////////////////////
// counter, comparators and clears
wire enable_rise = counter_enable & ~enable_d;
wire run         = counter_enable & ~count_pause & count_tick;
wire match_a     = run & (count == compare_a_value);
wire match_p     = run & (count == compare_p_value);
wire wrap        = run & (count == `PTMR_CNT_MAX);
wire is_pwm      = (operating_mode_select == `PTMR_MODE_PWM);
wire single      = is_pwm & (output_function_select == `PTMR_OF_TOGGLE);
wire p_zero      = (compare_p_value == 10'h000);
reg  clear_now;
reg  ev_a;
reg  ev_p;
reg  ev_ovf;

always @*
begin
  clear_now = 1'b0;
  ev_a      = match_a;
  ev_p      = match_p;
  ev_ovf    = wrap;
  // an all-zero P value means run to overflow, not clear at count zero
  if (single)
    ev_p = 1'b0;
  else if (is_pwm)
    clear_now = (match_p & ~p_zero) | (p_zero & wrap);
  else if (counter_clear_select)
  begin
    clear_now = match_a;
    ev_p      = 1'b0;
  end
  else
    clear_now = (match_p & ~p_zero) | (p_zero & wrap);
  // compare A value zero never flags in compare/timer modes
  if (!is_pwm && compare_a_value == 10'h000)
    ev_a = 1'b0;
end

always @(posedge aclk)
begin
  if (!aresetn)
  begin
    count    <= 10'h000;
    enable_d <= 1'b0;
  end
  else
  begin
    enable_d <= counter_enable;
    // software cannot load the count; only enable rise or clear_now clears it
    if (enable_rise || clear_now)
      count <= 10'h000;
    else if (run && !(single && match_a))
      count <= count + 10'h001;
  end
end

////////////////////////////////////////////////////////////////////////////////
// control and compare register writes
always @(posedge aclk)
begin
  if (!aresetn)
  begin
    ctrl0           <= `PTMR_RST_BYTE;
    ctrl1           <= `PTMR_RST_BYTE;
    compare_a_value <= 10'h000;
    compare_p_value <= 10'h000;
    irq_mask        <= 3'h0;
  end
  else
  begin
    if (wr_lane0 && wr_hit(wr_addr, `PTMR_OFF_CTRL0))
      ctrl0 <= {wb[7:3], 3'h0};
    else if (single && match_a)
      ctrl0[`PTMR_C0_ENABLE] <= 1'b0;
    else if (single && ext_s2 && !ext_s3)
      ctrl0[`PTMR_C0_ENABLE] <= 1'b1;
    if (wr_lane0 && wr_hit(wr_addr, `PTMR_OFF_CTRL1))
      ctrl1 <= {wb[7:2], 1'b0, wb[0]};
    if (wr_lane0 && wr_hit(wr_addr, `PTMR_OFF_CMPA_LO))
      compare_a_value[7:0] <= wb;
    if (wr_lane0 && wr_hit(wr_addr, `PTMR_OFF_CMPA_HI))
      compare_a_value[9:8] <= wb[1:0];
    if (wr_lane0 && wr_hit(wr_addr, `PTMR_OFF_CMPP_LO))
      compare_p_value[7:0] <= wb;
    if (wr_lane0 && wr_hit(wr_addr, `PTMR_OFF_CMPP_HI))
      compare_p_value[9:8] <= wb[1:0];
    if (wr_lane0 && wr_hit(wr_addr, `PTMR_OFF_IRQ_MASK))
      irq_mask <= wb[`PTMR_ST_W-1:0];
  end
end

////////////////////////////////////////////////////////////////////////////////
// interrupt status: set wins over write-one-to-clear
wire [`PTMR_ST_W-1:0] ev_vec = {ev_ovf, ev_p, ev_a};
wire [`PTMR_ST_W-1:0] w1c    =
  (wr_lane0 && wr_hit(wr_addr, `PTMR_OFF_IRQ_STAT)) ? wb[`PTMR_ST_W-1:0] : 3'h0;

always @(posedge aclk)
begin
  if (!aresetn)
  begin
    irq_stat <= 3'h0;
    irq      <= 1'b0;
  end
  else
  begin
    irq_stat <= (irq_stat & ~w1c) | ev_vec;
    irq      <= |(((irq_stat & ~w1c) | ev_vec) & irq_mask);
  end
end

////////////////////////////////////////////////////////////////////////////////
// output pin logic
always @(posedge aclk)
begin
  if (!aresetn)
    out_level <= 1'b0;
  else if (enable_rise)
    out_level <= output_control;
  else if (operating_mode_select == `PTMR_MODE_CMP && ev_a)
  begin
    case (output_function_select)
      `PTMR_OF_LOW:    out_level <= 1'b0;
      `PTMR_OF_HIGH:   out_level <= 1'b1;
      `PTMR_OF_TOGGLE: out_level <= ~out_level;
      default:         out_level <= out_level;
    endcase
  end
  else if (is_pwm && !single)
  begin
    if (output_function_select == `PTMR_OF_NONE)
      out_level <= ~output_control;
    else if (output_function_select == `PTMR_OF_LOW)
      out_level <= output_control;
    else if (clear_now || enable_rise)
      out_level <= output_control;
    else if (match_a)
      out_level <= ~output_control;
  end
  else if (single && (match_a || !counter_enable))
    out_level <= ~output_control;
end
// two driven pins: true and complementary, polarity applied to both
always @(posedge aclk)
begin
  if (!aresetn)
  begin
    timer_out   <= 1'b0;
    timer_out_n <= 1'b1;
  end
  else
  begin
    timer_out   <= out_level ^ output_polarity;
    timer_out_n <= ~(out_level ^ output_polarity);
  end
end

endmodule // ptmr_core

// ==== test/ptmr_core_asserts.sv ====
// ptmr_core_asserts.sv: port-level checks of the periodic timer core
// assumes: bound into ptmr_core; a write offers address and data together
module ptmr_chk
(
  // clock and reset
  input logic        aclk,
  input logic        aresetn,
  // register bus
  input logic [7:0]  s_axi_awaddr,
  input logic        s_axi_awvalid,
  input logic        s_axi_awready,
  input logic [31:0] s_axi_wdata,
  input logic        s_axi_wvalid,
  input logic        s_axi_wready,
  input logic        s_axi_bvalid,
  input logic [7:0]  s_axi_araddr,
  input logic        s_axi_arvalid,
  input logic        s_axi_arready,
  input logic [31:0] s_axi_rdata,
  input logic [1:0]  s_axi_rresp,
  input logic        s_axi_rvalid,
  // pins
  input logic        timer_out,
  input logic        timer_out_n,
  input logic        irq
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  ////////////////////////////////////////////////////////////////////////////
  sequence ar_take;
    s_axi_arvalid && s_axi_arready;
  endsequence
  sequence wr_take;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence mask_off;
    wr_take ##0 (s_axi_awaddr == 8'h24 && s_axi_wdata[2:0] == 3'h0);
  endsequence
  ////////////////////////////////////////////////////////////////////////////
  a_out_pair: assert property (timer_out_n == !timer_out)
    else $error("output pins not complementary");
  a_rd_answer: assert property (ar_take |=> s_axi_rvalid)
    else $error("read answer late");
  a_rd_byte: assert property (ar_take |=> s_axi_rdata[31:8] == 24'h0)
    else $error("read data above byte not zero");
  a_ctrl0_zero: assert property (
    ar_take ##0 (s_axi_araddr == 8'h00) |=> s_axi_rdata[2:0] == 3'h0)
    else $error("control 0 low bits not zero");
  a_hi_zero: assert property (
    ar_take ##0 (s_axi_araddr == 8'h0C || s_axi_araddr == 8'h14 || s_axi_araddr == 8'h1C)
    |=> s_axi_rdata[31:2] == 30'h0)
    else $error("high part upper bits not zero");
  a_unmapped_rd: assert property (
    ar_take ##0 (s_axi_araddr > 8'h24) |=> s_axi_rresp == 2'h2 && s_axi_rdata == 32'h0)
    else $error("unmapped read not refused");
  a_wr_answer: assert property (wr_take |=> s_axi_bvalid)
    else $error("write answer late");
  a_irq_masked: assert property (mask_off |-> ##[1:2] !irq ##1 !irq)
    else $error("interrupt not masked");
endmodule // ptmr_chk

// ==== test/ptmr_core_tb.sv ====
// ptmr_core_tb.sv: self-checking bench for the periodic timer core
// assumes: ptmr_core and its header on the include path, 200 MHz aclk
module ptmr_core_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic        aclk, aresetn, high_clk_tick, sub_clk_tick, ext_count_clock_pin;
  logic [7:0]  s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, v1, v2;
  logic [3:0]  s_axi_wstrb;
  logic        s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0]  s_axi_bresp, s_axi_rresp, resp;
  logic        timer_out, timer_out_n, irq;
  logic [9:0]  tbl [0:4];
  int          mismatches, checks;
  ////////////////////////////////////////////////////////////////////////////
  ptmr_core u_dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .high_clk_tick,
    .sub_clk_tick, .ext_count_clock_pin, .timer_out, .timer_out_n, .irq);
  always #2.5 aclk = ~aclk;
  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  // ready is looked at on the falling edge; inputs are steady until the next rise
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic ta, tw, done;
    int   n;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= {24'h0, d};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    done = 1'b0;
    n = 0;
    while (!done && n < 100)
    begin
      @(negedge aclk);
      ta = s_axi_awvalid && s_axi_awready;
      tw = s_axi_wvalid && s_axi_wready;
      done = s_axi_bvalid;
      resp = s_axi_bresp;
      @(posedge aclk);
      if (ta) s_axi_awvalid <= 1'b0;
      if (tw) s_axi_wvalid <= 1'b0;
      n++;
    end
    s_axi_bready <= 1'b0;
    if (!done) mismatches++;
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    logic ta, done;
    int   n;
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    done = 1'b0;
    n = 0;
    while (!done && n < 100)
    begin
      @(negedge aclk);
      ta = s_axi_arvalid && s_axi_arready;
      done = s_axi_rvalid;
      d = s_axi_rdata;
      resp = s_axi_rresp;
      @(posedge aclk);
      if (ta) s_axi_arvalid <= 1'b0;
      n++;
    end
    s_axi_rready <= 1'b0;
    if (!done) mismatches++;
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] v;
    rd(a, v);
    chk(v, exp);
  endtask
  // one full pin period per step, wide enough for the two-flop synchroniser
  task automatic pulse(input int n);
    repeat (n)
    begin
      repeat (4) @(posedge aclk);
      ext_count_clock_pin <= ~ext_count_clock_pin;
      repeat (4) @(posedge aclk);
      ext_count_clock_pin <= ~ext_count_clock_pin;
    end
    repeat (8) @(posedge aclk);
  endtask
  // enable, run 40 cycles, pause, then read the frozen count against a window
  task automatic rate(input logic [7:0] sel, input logic [31:0] lo, input logic [31:0] hi);
    logic [31:0] v;
    wr(8'h00, sel | 8'h08);
    repeat (40) @(posedge aclk);
    wr(8'h00, sel | 8'h88);
    rd(8'h08, v);
    chk(32'(v >= lo && v <= hi), 32'h1);
    wr(8'h00, sel);
  endtask
  task automatic close_out;
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    repeat (20000) @(posedge aclk);
    mismatches++;
    close_out;
  end
  initial
  begin
    {aclk, aresetn, high_clk_tick, sub_clk_tick, ext_count_clock_pin} = 5'h0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} = 52'h1;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h0;
    tbl = '{{8'h20, 2'h1}, {8'h18, 2'h2}, {8'h30, 2'h1}, {8'h08, 2'h3}, {8'h24, 2'h2}};
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
    rdc(8'h00, 32'h0);
    rdc(8'h04, 32'h0);
    rdc(8'h08, 32'h0);
    rdc(8'h0C, 32'h0);
    rdc(8'h1C, 32'h0);
    $display("reset test done");
    wr(8'h14, 8'hFF);
    rdc(8'h14, 32'h3);
    wr(8'h10, 8'hA5);
    rdc(8'h10, 32'hA5);
    wr(8'h08, 8'h55);
    rdc(8'h08, 32'h0);
    wr(8'h00, 8'hF7);
    rdc(8'h00, 32'hF0);
    wr(8'h04, 8'hC2);
    rdc(8'h04, 32'hC0);
    wr(8'h40, 8'h01);
    chk(32'(resp), 32'h2);
    rdc(8'h40, 32'h0);
    $display("register test done");
    wr(8'h00, 8'h00);
    wr(8'h10, 8'h00);
    wr(8'h14, 8'h00);
    wr(8'h00, 8'h68);
    pulse(5);
    rdc(8'h08, 32'h5);
    wr(8'h00, 8'h60);
    pulse(2);
    rdc(8'h08, 32'h5);
    wr(8'h00, 8'h78);
    pulse(3);
    rdc(8'h08, 32'h3);
    $display("pin clock test done");
    wr(8'h00, 8'h10);
    wr(8'h00, 8'h18);
    wr(8'h00, 8'h98);
    rd(8'h08, v1);
    rd(8'h08, v2);
    chk(v2, v1);
    wr(8'h00, 8'h18);
    rd(8'h08, v2);
    chk(32'(v2 !== v1), 32'h1);
    wr(8'h00, 8'h10);
    $display("pause test done");
    wr(8'h18, 8'h04);
    wr(8'h20, 8'h07);
    wr(8'h24, 8'h02);
    wr(8'h00, 8'h18);
    repeat (20) @(posedge aclk);
    @(negedge aclk);
    chk(32'(irq), 32'h1);
    rd(8'h08, v1);
    chk(32'(v1 <= 32'h4), 32'h1);
    wr(8'h00, 8'h10);
    wr(8'h24, 8'h00);
    @(negedge aclk);
    chk(32'(irq), 32'h0);
    wr(8'h20, 8'h07);
    rdc(8'h20, 32'h0);
    wr(8'h18, 8'h00);
    wr(8'h00, 8'h18);
    repeat (1100) @(posedge aclk);
    wr(8'h00, 8'h10);
    rd(8'h20, v1);
    chk(v1 & 32'h4, 32'h4);
    wr(8'h10, 8'h03);
    wr(8'h04, 8'hC1);
    wr(8'h20, 8'h07);
    wr(8'h00, 8'h18);
    repeat (20) @(posedge aclk);
    wr(8'h00, 8'h10);
    rdc(8'h20, 32'h1);
    $display("clear source test done");
    // enable rises while paused so the initial level can be seen before a match
    foreach (tbl[i])
    begin
      wr(8'h04, tbl[i][9:2]);
      wr(8'h00, 8'h98);
      // the pin sits two registers behind the enable write
      repeat (2) @(negedge aclk);
      chk(32'(timer_out), 32'(tbl[i][1]));
      wr(8'h00, 8'h18);
      repeat (10) @(posedge aclk);
      @(negedge aclk);
      chk(32'(timer_out), 32'(tbl[i][0]));
      wr(8'h00, 8'h10);
    end
    $display("output test done");
    high_clk_tick <= 1'b1;
    sub_clk_tick <= 1'b1;
    rate(8'h10, 32'h2A, 32'h2A);
    rate(8'h00, 32'hA, 32'hB);
    rate(8'h20, 32'h2, 32'h3);
    rate(8'h40, 32'h2A, 32'h2A);
    $display("clock rate test done");
    // single pulse: a pin rise sets enable, an A match at 3 ends the pulse
    wr(8'h04, 8'hB8);
    pulse(1);
    rdc(8'h00, 32'h40);
    rdc(8'h08, 32'h3);
    @(negedge aclk);
    chk(32'(timer_out), 32'h0);
    $display("single pulse test done");
    close_out;
  end
endmodule // ptmr_core_tb
bind ptmr_core ptmr_chk u_chk (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid,
  .s_axi_awready, .s_axi_wdata, .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid,
  .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
  .s_axi_rvalid, .timer_out, .timer_out_n, .irq);
